// ### design/tit_pkg.sv
// constants, opcodes and carrier types for the interrupt/timer transfer executor
// assumes a 10-bit instruction word and 4-bit accumulator and extension register
package tit_pkg;
  localparam int NIB_W = 4;
  localparam int T1_W = 10;
  localparam int T8_W = 8;
  localparam int STORE_W = 2;
  localparam int INSTR_W = 10;
  localparam int BUS_AW = 2;
  localparam int BUS_DW = 8;

  // instruction codes
  localparam logic [9:0] OP_INT_DISABLE = 10'h004;
  localparam logic [9:0] OP_INT_ENABLE = 10'h005;
  localparam logic [9:0] OP_SKIP_REQ = 10'h038;
  localparam logic [9:0] OP_SKIP_PIN = 10'h03a;
  localparam logic [9:0] OP_TAV1 = 10'h054;
  localparam logic [9:0] OP_TV1A = 10'h03f;
  localparam logic [9:0] OP_TAV2 = 10'h055;
  localparam logic [9:0] OP_TV2A = 10'h03e;
  localparam logic [9:0] OP_TAI1 = 10'h253;
  localparam logic [9:0] OP_TI1A = 10'h217;
  localparam logic [9:0] OP_TAW1 = 10'h24b;
  localparam logic [9:0] OP_TW1A = 10'h20e;
  localparam logic [9:0] OP_TAW2 = 10'h24c;
  localparam logic [9:0] OP_TW2A = 10'h20f;
  localparam logic [9:0] OP_TAW3 = 10'h24d;
  localparam logic [9:0] OP_TW3A = 10'h210;
  localparam logic [9:0] OP_TAW5 = 10'h24f;
  localparam logic [9:0] OP_TW5A = 10'h212;
  localparam logic [9:0] OP_T1_READ = 10'h270;
  localparam logic [9:0] OP_T1_LOAD = 10'h230;
  localparam logic [9:0] OP_T2_READ = 10'h271;
  localparam logic [9:0] OP_T2_LOAD = 10'h231;
  localparam logic [9:0] OP_T2_RELOAD = 10'h23a;
  localparam logic [9:0] OP_T3_READ = 10'h272;
  localparam logic [9:0] OP_T3_LOAD = 10'h232;
  localparam logic [9:0] OP_T3_HRELOAD = 10'h23d;

  // field positions
  localparam int POLARITY_BIT = 2;
  localparam int T1_RUN_BIT = 0;

  // register bus map
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_MASK = 2'h1;
  localparam logic [1:0] ADDR_FLAGS = 2'h2;
  localparam int EV_SKIP = 0;
  localparam int EV_EXT_TAKEN = 1;
  localparam int EV_TLOAD = 2;
  localparam int EV_N = 3;

  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [9:0] T1_RST = 10'h000;

  typedef struct packed {
    logic acc_we;
    logic [3:0] acc;
    logic ext_we;
    logic [3:0] ext;
  } tit_wb_t;

  typedef struct packed {
    logic t1_we;
    logic [9:0] t1;
    logic t2_we;
    logic [7:0] t2;
    logic t3_we;
    logic [7:0] t3;
  } tit_tload_t;
endpackage

// ### design/tit_instr_exec.sv
// executor for the interrupt-flag, interrupt-control and timer transfer instructions
// assumes the core sequencer presents one instruction per instr_valid cycle and
// applies wb and tload one cycle after the instruction was taken
//
// Summary of operation
// - disable instruction clears interrupt enable flag to 0
// - enable instruction sets interrupt enable flag to 1
// - skip-on-request skips when request flag is 1, then clears it
// - skip-on-pin tests pin high if polarity bit 2 is 1, else low
// - read instructions copy interrupt control registers into accumulator unchanged
// - write instructions copy accumulator into one interrupt control register
// - read instructions copy timer control registers into accumulator
// - write instructions copy accumulator into timer control registers
// - count store read fills accumulator low 2 bits, upper two zero
// - count store write takes only the low two accumulator bits
// - timer 1 read: bits 9-8 to store, 7-4 extension, 3-0 accumulator
// - timer 1 load: reload always, counter only while run bit is 0
// - timer 2 read: bits 7-4 to extension, 3-0 to accumulator
// - timer 2 load writes counter and reload from extension and accumulator
// - timer 2 reload-only writes reload register, counter untouched
// - timer 3 read: bits 7-4 to extension, 3-0 to accumulator
// - timer 3 load writes counter and low reload register
// - timer 3 high-reload writes high reload register only
module tit_instr_exec (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [9:0] instr,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] ext_in,
  input wire logic ext_irq_event,
  input wire logic external_interrupt_pin,
  input wire logic [9:0] timer1_count,
  input wire logic [7:0] timer2_count,
  input wire logic [7:0] timer3_count,
  output tit_pkg::tit_wb_t wb,
  output tit_pkg::tit_tload_t tload,
  output logic skip_active,
  output logic interrupt_enable_flag,
  output logic ext_irq_request_flag,
  output logic [3:0] int_ctrl_v1,
  output logic [3:0] int_ctrl_v2,
  output logic [3:0] int_ctrl_1,
  output logic [3:0] timer_ctrl_1,
  output logic [3:0] timer_ctrl_2,
  output logic [3:0] timer_ctrl_3,
  output logic [1:0] timer_count_store,
  output logic [9:0] timer1_reload,
  output logic [7:0] timer2_reload,
  output logic [7:0] timer3_reload_low,
  output logic [7:0] timer3_reload_high,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq
);
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic skip_pending_reg;
  logic exec;
  logic skip_cond;
  logic ext_taken;
  logic t1_run;
  logic [7:0] ab;
  tit_pkg::tit_wb_t wb_reg;
  tit_pkg::tit_wb_t wb_next;
  tit_pkg::tit_tload_t tload_reg;
  tit_pkg::tit_tload_t tload_next;
  logic ie_reg;
  logic ext_req_reg;
  logic [3:0] int_ctrl_v1_reg;
  logic [3:0] int_ctrl_v2_reg;
  logic [3:0] int_ctrl_1_reg;
  logic [3:0] timer_ctrl_1_reg;
  logic [3:0] timer_ctrl_2_reg;
  logic [3:0] timer_ctrl_3_reg;
  logic [1:0] store_reg;
  logic [9:0] t1_reload_reg;
  logic [7:0] t2_reload_reg;
  logic [7:0] t3_low_reg;
  logic [7:0] t3_high_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic [2:0] events;
  logic [7:0] rdata_reg;

  // pin passes two flip-flops before any logic looks at it
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= external_interrupt_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // an instruction flagged for skipping is dropped without effect
  assign exec = instr_valid && !skip_pending_reg;
  assign t1_run = timer_ctrl_1_reg[tit_pkg::T1_RUN_BIT];
  assign ab = {ext_in, acc_in};

  assign skip_cond = exec && ((instr == tit_pkg::OP_SKIP_REQ && ext_req_reg)
    || (instr == tit_pkg::OP_SKIP_PIN
    && pin_sync_reg == int_ctrl_1_reg[tit_pkg::POLARITY_BIT]));

  assign ext_taken = exec && instr == tit_pkg::OP_SKIP_REQ && ext_req_reg;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      skip_pending_reg <= 1'b0;
    end
    else if (skip_cond)
    begin
      skip_pending_reg <= 1'b1;
    end
    else if (instr_valid)
    begin
      skip_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ie_reg <= 1'b0;
    end
    else if (exec && instr == tit_pkg::OP_INT_DISABLE)
    begin
      ie_reg <= 1'b0;
    end
    else if (exec && instr == tit_pkg::OP_INT_ENABLE)
    begin
      ie_reg <= 1'b1;
    end
  end

  // a new request in the same cycle as the skip survives
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_req_reg <= 1'b0;
    end
    else if (ext_irq_event)
    begin
      ext_req_reg <= 1'b1;
    end
    else if (ext_taken)
    begin
      ext_req_reg <= 1'b0;
    end
  end

  // control register writes from the accumulator; count store also loaded by timer 1 read
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_ctrl_v1_reg <= tit_pkg::NIB_RST;
      int_ctrl_v2_reg <= tit_pkg::NIB_RST;
      int_ctrl_1_reg <= tit_pkg::NIB_RST;
      timer_ctrl_1_reg <= tit_pkg::NIB_RST;
      timer_ctrl_2_reg <= tit_pkg::NIB_RST;
      timer_ctrl_3_reg <= tit_pkg::NIB_RST;
      store_reg <= 2'h0;
    end
    else if (exec)
    begin
      unique case (instr)
        tit_pkg::OP_TV1A: int_ctrl_v1_reg <= acc_in;
        tit_pkg::OP_TV2A: int_ctrl_v2_reg <= acc_in;
        tit_pkg::OP_TI1A: int_ctrl_1_reg <= acc_in;
        tit_pkg::OP_TW1A: timer_ctrl_1_reg <= acc_in;
        tit_pkg::OP_TW2A: timer_ctrl_2_reg <= acc_in;
        tit_pkg::OP_TW3A: timer_ctrl_3_reg <= acc_in;
        tit_pkg::OP_TW5A: store_reg <= acc_in[1:0];
        tit_pkg::OP_T1_READ: store_reg <= timer1_count[9:8];
        default: store_reg <= store_reg;
      endcase
    end
  end

  // reload registers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      t1_reload_reg <= tit_pkg::T1_RST;
      t2_reload_reg <= tit_pkg::BYTE_RST;
      t3_low_reg <= tit_pkg::BYTE_RST;
      t3_high_reg <= tit_pkg::BYTE_RST;
    end
    else if (exec)
    begin
      unique case (instr)
        tit_pkg::OP_T1_LOAD: t1_reload_reg <= {store_reg, ab};
        tit_pkg::OP_T2_LOAD: t2_reload_reg <= ab;
        tit_pkg::OP_T2_RELOAD: t2_reload_reg <= ab;
        tit_pkg::OP_T3_LOAD: t3_low_reg <= ab;
        tit_pkg::OP_T3_HRELOAD: t3_high_reg <= ab;
        default: t3_high_reg <= t3_high_reg;
      endcase
    end
  end

  // accumulator and extension write-back
  always_comb
  begin
    wb_next = '0;
    if (exec)
    begin
      unique case (instr)
        tit_pkg::OP_TAV1: wb_next.acc = int_ctrl_v1_reg;
        tit_pkg::OP_TAV2: wb_next.acc = int_ctrl_v2_reg;
        tit_pkg::OP_TAI1: wb_next.acc = int_ctrl_1_reg;
        tit_pkg::OP_TAW1: wb_next.acc = timer_ctrl_1_reg;
        tit_pkg::OP_TAW2: wb_next.acc = timer_ctrl_2_reg;
        tit_pkg::OP_TAW3: wb_next.acc = timer_ctrl_3_reg;
        tit_pkg::OP_TAW5: wb_next.acc = {2'b00, store_reg};
        tit_pkg::OP_T1_READ: {wb_next.ext, wb_next.acc} = timer1_count[7:0];
        tit_pkg::OP_T2_READ: {wb_next.ext, wb_next.acc} = timer2_count;
        tit_pkg::OP_T3_READ: {wb_next.ext, wb_next.acc} = timer3_count;
        default: wb_next.acc = 4'h0;
      endcase
      unique case (instr)
        tit_pkg::OP_TAV1, tit_pkg::OP_TAV2, tit_pkg::OP_TAI1, tit_pkg::OP_TAW1,
        tit_pkg::OP_TAW2, tit_pkg::OP_TAW3, tit_pkg::OP_TAW5: wb_next.acc_we = 1'b1;
        tit_pkg::OP_T1_READ, tit_pkg::OP_T2_READ, tit_pkg::OP_T3_READ:
        begin
          wb_next.acc_we = 1'b1;
          wb_next.ext_we = 1'b1;
        end
        default: wb_next.acc_we = 1'b0;
      endcase
    end
  end

  // counter load strobes
  always_comb
  begin
    tload_next.t1_we = exec && instr == tit_pkg::OP_T1_LOAD && !t1_run;
    tload_next.t1 = {store_reg, ab};
    tload_next.t2_we = exec && instr == tit_pkg::OP_T2_LOAD;
    tload_next.t2 = ab;
    tload_next.t3_we = exec && instr == tit_pkg::OP_T3_LOAD;
    tload_next.t3 = ab;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_reg <= '0;
      tload_reg <= '0;
    end
    else
    begin
      wb_reg <= wb_next;
      tload_reg <= tload_next;
    end
  end

  // sticky events, cleared by a status read; a new event wins
  assign events = {tload_next.t1_we || tload_next.t2_we || tload_next.t3_we,
                   ext_taken, skip_cond};
  assign status_next = ((reg_rd && reg_addr == tit_pkg::ADDR_STATUS) ? 3'h0 : status_reg)
    | events;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_reg <= 3'h0;
      mask_reg <= 3'h0;
    end
    else
    begin
      status_reg <= status_next;
      if (reg_wr && reg_addr == tit_pkg::ADDR_MASK)
      begin
        mask_reg <= reg_wdata[2:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= tit_pkg::BYTE_RST;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        tit_pkg::ADDR_STATUS: rdata_reg <= {5'h00, status_reg};
        tit_pkg::ADDR_MASK: rdata_reg <= {5'h00, mask_reg};
        tit_pkg::ADDR_FLAGS:
          rdata_reg <= {4'h0, skip_pending_reg, pin_sync_reg, ext_req_reg, ie_reg};
        default: rdata_reg <= tit_pkg::BYTE_RST;
      endcase
    end
    else
    begin
      rdata_reg <= tit_pkg::BYTE_RST;
    end
  end

  assign wb = wb_reg;
  assign tload = tload_reg;
  assign skip_active = skip_pending_reg;
  assign interrupt_enable_flag = ie_reg;
  assign ext_irq_request_flag = ext_req_reg;
  assign int_ctrl_v1 = int_ctrl_v1_reg;
  assign int_ctrl_v2 = int_ctrl_v2_reg;
  assign int_ctrl_1 = int_ctrl_1_reg;
  assign timer_ctrl_1 = timer_ctrl_1_reg;
  assign timer_ctrl_2 = timer_ctrl_2_reg;
  assign timer_ctrl_3 = timer_ctrl_3_reg;
  assign timer_count_store = store_reg;
  assign timer1_reload = t1_reload_reg;
  assign timer2_reload = t2_reload_reg;
  assign timer3_reload_low = t3_low_reg;
  assign timer3_reload_high = t3_high_reg;
  assign reg_rdata = rdata_reg;
  assign irq = |(status_reg & mask_reg);

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_op(logic [9:0] op);
    exec && instr == op;
  endsequence
  sequence s_skip_armed;
    skip_pending_reg && instr_valid;
  endsequence

  property p_dis_int;
    s_op(tit_pkg::OP_INT_DISABLE) |=> !interrupt_enable_flag;
  endproperty
  a_dis_int: assert property (p_dis_int) else $error("disable left enable flag set");
  property p_en_int;
    s_op(tit_pkg::OP_INT_ENABLE) |=> interrupt_enable_flag;
  endproperty
  a_en_int: assert property (p_en_int) else $error("enable did not set flag");
  property p_skip_req;
    s_op(tit_pkg::OP_SKIP_REQ) ##0 (ext_irq_request_flag && !ext_irq_event)
      |=> skip_active && !ext_irq_request_flag;
  endproperty
  a_skip_req: assert property (p_skip_req) else $error("request skip or clear missing");
  property p_skip_pin;
    s_op(tit_pkg::OP_SKIP_PIN) |=>
      skip_active == ($past(int_ctrl_1[2]) ? $past(pin_sync_reg) : !$past(pin_sync_reg));
  endproperty
  a_skip_pin: assert property (p_skip_pin) else $error("pin level skip wrong");
  property p_tav1;
    s_op(tit_pkg::OP_TAV1) |=> wb.acc_we && wb.acc == $past(int_ctrl_v1)
      && int_ctrl_v1 == $past(int_ctrl_v1);
  endproperty
  a_tav1: assert property (p_tav1) else $error("control read wrong");
  property p_ti1a;
    s_op(tit_pkg::OP_TI1A) |=> int_ctrl_1 == $past(acc_in) && wb.acc_we == 1'b0;
  endproperty
  a_ti1a: assert property (p_ti1a) else $error("control write wrong");
  property p_taw5;
    s_op(tit_pkg::OP_TAW5) |=> wb.acc == {2'b00, $past(timer_count_store)};
  endproperty
  a_taw5: assert property (p_taw5) else $error("store read wrong");
  property p_t1load;
    s_op(tit_pkg::OP_T1_LOAD) |=> timer1_reload == {$past(timer_count_store), $past(ab)}
      && tload.t1_we == !$past(timer_ctrl_1[0]);
  endproperty
  a_t1load: assert property (p_t1load) else $error("timer 1 load wrong");
  property p_t2reload;
    s_op(tit_pkg::OP_T2_RELOAD) |=> !tload.t2_we && timer2_reload == $past(ab);
  endproperty
  a_t2reload: assert property (p_t2reload) else $error("reload-only touched counter");
  property p_t3high;
    s_op(tit_pkg::OP_T3_HRELOAD) |=> !tload.t3_we && timer3_reload_high == $past(ab)
      && timer3_reload_low == $past(timer3_reload_low);
  endproperty
  a_t3high: assert property (p_t3high) else $error("high reload wrong");
  property p_discard;
    s_skip_armed |=> !skip_active && !wb.acc_we && !tload.t1_we && !tload.t2_we
      && interrupt_enable_flag == $past(interrupt_enable_flag);
  endproperty
  a_discard: assert property (p_discard) else $error("skipped instruction acted");
endmodule

// ### testbench/tit_instr_exec_tb_top.sv
// self-checking bench for the interrupt/timer transfer instruction executor
// assumes tit_pkg is compiled first; the bench drives every port itself
module tit_instr_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [9:0] op;
    logic [3:0] a;
    logic [3:0] e;
    logic awe;
    logic [3:0] av;
    logic ewe;
    logic [3:0] ev;
  } tit_row_t;

  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [9:0] instr = 10'h000;
  logic [3:0] acc_in = 4'h0;
  logic [3:0] ext_in = 4'h0;
  logic ext_irq_event = 1'b0;
  logic external_interrupt_pin = 1'b0;
  logic [9:0] timer1_count = 10'h2a5;
  logic [7:0] timer2_count = 8'h3c;
  logic [7:0] timer3_count = 8'h96;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  tit_pkg::tit_wb_t wb;
  tit_pkg::tit_tload_t tload;
  logic skip_active, interrupt_enable_flag, ext_irq_request_flag;
  logic [3:0] int_ctrl_v1, int_ctrl_v2, int_ctrl_1;
  logic [3:0] timer_ctrl_1, timer_ctrl_2, timer_ctrl_3;
  logic [1:0] timer_count_store;
  logic [9:0] timer1_reload;
  logic [7:0] timer2_reload, timer3_reload_low, timer3_reload_high;
  logic [7:0] reg_rdata, rv;
  logic irq;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  tit_row_t rows [20];

  tit_instr_exec tit_instr_exec_inst (
    .mclk(mclk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
    .acc_in(acc_in), .ext_in(ext_in), .ext_irq_event(ext_irq_event),
    .external_interrupt_pin(external_interrupt_pin), .timer1_count(timer1_count),
    .timer2_count(timer2_count), .timer3_count(timer3_count), .wb(wb), .tload(tload),
    .skip_active(skip_active), .interrupt_enable_flag(interrupt_enable_flag),
    .ext_irq_request_flag(ext_irq_request_flag), .int_ctrl_v1(int_ctrl_v1),
    .int_ctrl_v2(int_ctrl_v2), .int_ctrl_1(int_ctrl_1), .timer_ctrl_1(timer_ctrl_1),
    .timer_ctrl_2(timer_ctrl_2), .timer_ctrl_3(timer_ctrl_3),
    .timer_count_store(timer_count_store), .timer1_reload(timer1_reload),
    .timer2_reload(timer2_reload), .timer3_reload_low(timer3_reload_low),
    .timer3_reload_high(timer3_reload_high), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );

  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles >= 3000)
    begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  // one instruction; results are sampled just after the taking edge
  task automatic exec(input logic [9:0] op, input logic [3:0] a, input logic [3:0] e);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr <= op;
    acc_in <= a;
    ext_in <= e;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic bus_wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [1:0] ad, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic pulse_event();
    @(posedge mclk);
    ext_irq_event <= 1'b1;
    @(posedge mclk);
    ext_irq_event <= 1'b0;
    #1;
  endtask

  initial
  begin
    rows = '{
      '{tit_pkg::OP_TV1A, 4'h3, 4'h0, 1'b0, 4'h0, 1'b0, 4'h0},
      '{tit_pkg::OP_TAV1, 4'h0, 4'h0, 1'b1, 4'h3, 1'b0, 4'h0},
      '{tit_pkg::OP_TV2A, 4'ha, 4'h0, 1'b0, 4'h0, 1'b0, 4'h0},
      '{tit_pkg::OP_TAV2, 4'h0, 4'h0, 1'b1, 4'ha, 1'b0, 4'h0},
      '{tit_pkg::OP_TI1A, 4'h6, 4'h0, 1'b0, 4'h0, 1'b0, 4'h0},
      '{tit_pkg::OP_TAI1, 4'h0, 4'h0, 1'b1, 4'h6, 1'b0, 4'h0},
      '{tit_pkg::OP_TAV1, 4'h0, 4'h0, 1'b1, 4'h3, 1'b0, 4'h0},
      '{tit_pkg::OP_TW1A, 4'h9, 4'h0, 1'b0, 4'h0, 1'b0, 4'h0},
      '{tit_pkg::OP_TAW1, 4'h0, 4'h0, 1'b1, 4'h9, 1'b0, 4'h0},
      '{tit_pkg::OP_TW2A, 4'hc, 4'h0, 1'b0, 4'h0, 1'b0, 4'h0},
      '{tit_pkg::OP_TAW2, 4'h0, 4'h0, 1'b1, 4'hc, 1'b0, 4'h0},
      '{tit_pkg::OP_TW3A, 4'h7, 4'h0, 1'b0, 4'h0, 1'b0, 4'h0},
      '{tit_pkg::OP_TAW3, 4'h0, 4'h0, 1'b1, 4'h7, 1'b0, 4'h0},
      '{tit_pkg::OP_TW5A, 4'hf, 4'h0, 1'b0, 4'h0, 1'b0, 4'h0},
      '{tit_pkg::OP_TAW5, 4'hf, 4'h0, 1'b1, 4'h3, 1'b0, 4'h0},
      '{tit_pkg::OP_TW5A, 4'h6, 4'h0, 1'b0, 4'h0, 1'b0, 4'h0},
      '{tit_pkg::OP_TAW5, 4'h0, 4'h0, 1'b1, 4'h2, 1'b0, 4'h0},
      '{tit_pkg::OP_T1_READ, 4'h0, 4'h0, 1'b1, 4'h5, 1'b1, 4'ha},
      '{tit_pkg::OP_T2_READ, 4'h0, 4'h0, 1'b1, 4'hc, 1'b1, 4'h3},
      '{tit_pkg::OP_T3_READ, 4'h0, 4'h0, 1'b1, 4'h6, 1'b1, 4'h9}
    };
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    chk("ie_flag_rst", 10'h000, 10'(interrupt_enable_flag));
    chk("skip_rst", 10'h000, 10'(skip_active));
    chk("t1_reload_rst", 10'h000, timer1_reload);
    chk("irq_rst", 10'h000, 10'(irq));
    foreach (rows[k])
    begin
      exec(rows[k].op, rows[k].a, rows[k].e);
      chk("wb_acc_we", 10'(rows[k].awe), 10'(wb.acc_we));
      chk("wb_ext_we", 10'(rows[k].ewe), 10'(wb.ext_we));
      if (rows[k].awe)
      begin
        chk("wb_acc", 10'(rows[k].av), 10'(wb.acc));
      end
      if (rows[k].ewe)
      begin
        chk("wb_ext", 10'(rows[k].ev), 10'(wb.ext));
      end
    end
    chk("count_store", 10'h002, 10'(timer_count_store));
    chk("ictl_v1", 10'h003, 10'(int_ctrl_v1));
    chk("ictl_v2", 10'h00a, 10'(int_ctrl_v2));
    chk("tctl_2", 10'h00c, 10'(timer_ctrl_2));
    chk("tctl_3", 10'h007, 10'(timer_ctrl_3));
    exec(10'h3ff, 4'h1, 4'h1);
    chk("unknown_op_wb", 10'h000, 10'({wb.acc_we, wb.ext_we}));
    // run bit is set: reload only
    exec(tit_pkg::OP_T1_LOAD, 4'h2, 4'h4);
    chk("t1_we_run", 10'h000, 10'(tload.t1_we));
    chk("t1_reload_run", 10'h242, timer1_reload);
    exec(tit_pkg::OP_TW1A, 4'h8, 4'h0);
    exec(tit_pkg::OP_T1_LOAD, 4'h7, 4'h1);
    chk("t1_we_stop", 10'h001, 10'(tload.t1_we));
    chk("t1_val", 10'h217, tload.t1);
    chk("t1_reload", 10'h217, timer1_reload);
    exec(tit_pkg::OP_T2_LOAD, 4'ha, 4'h5);
    chk("t2_we", 10'h001, 10'(tload.t2_we));
    chk("t2_val", 10'h05a, 10'(tload.t2));
    chk("t2_reload", 10'h05a, 10'(timer2_reload));
    exec(tit_pkg::OP_T2_RELOAD, 4'h2, 4'h1);
    chk("t2_we_rl", 10'h000, 10'(tload.t2_we));
    chk("t2_reload_rl", 10'h012, 10'(timer2_reload));
    exec(tit_pkg::OP_T3_LOAD, 4'he, 4'h7);
    chk("t3_we", 10'h001, 10'(tload.t3_we));
    chk("t3_val", 10'h07e, 10'(tload.t3));
    chk("t3_low", 10'h07e, 10'(timer3_reload_low));
    exec(tit_pkg::OP_T3_HRELOAD, 4'hd, 4'hc);
    chk("t3_we_h", 10'h000, 10'(tload.t3_we));
    chk("t3_high", 10'h0cd, 10'(timer3_reload_high));
    chk("t3_low_kept", 10'h07e, 10'(timer3_reload_low));
    exec(tit_pkg::OP_INT_ENABLE, 4'h0, 4'h0);
    chk("ie_set", 10'h001, 10'(interrupt_enable_flag));
    exec(tit_pkg::OP_INT_DISABLE, 4'h0, 4'h0);
    chk("ie_clr", 10'h000, 10'(interrupt_enable_flag));
    // pin skip: every polarity and level
    for (int k = 0; k < 4; k++)
    begin
      exec(tit_pkg::OP_TI1A, {1'b0, k[1], 2'b00}, 4'h0);
      @(posedge mclk);
      external_interrupt_pin <= k[0];
      repeat (3) @(posedge mclk);
      exec(tit_pkg::OP_SKIP_PIN, 4'h0, 4'h0);
      chk("pin_skip", 10'(k[1] == k[0]), 10'(skip_active));
      exec(tit_pkg::OP_INT_DISABLE, 4'h0, 4'h0);
      chk("skip_done", 10'h000, 10'(skip_active));
    end
    bus_rd(tit_pkg::ADDR_STATUS, rv);
    bus_wr(tit_pkg::ADDR_MASK, 8'h00);
    pulse_event();
    chk("req_flag", 10'h001, 10'(ext_irq_request_flag));
    exec(tit_pkg::OP_SKIP_REQ, 4'h0, 4'h0);
    chk("req_skip", 10'h001, 10'(skip_active));
    chk("req_cleared", 10'h000, 10'(ext_irq_request_flag));
    exec(tit_pkg::OP_INT_ENABLE, 4'h0, 4'h0);
    chk("discarded_ie", 10'h000, 10'(interrupt_enable_flag));
    chk("skip_consumed", 10'h000, 10'(skip_active));
    exec(tit_pkg::OP_SKIP_REQ, 4'h0, 4'h0);
    chk("no_req_skip", 10'h000, 10'(skip_active));
    chk("irq_masked", 10'h000, 10'(irq));
    bus_wr(tit_pkg::ADDR_STATUS, 8'hff);
    bus_wr(tit_pkg::ADDR_MASK, 8'h02);
    #1;
    chk("irq_on", 10'h001, 10'(irq));
    bus_rd(tit_pkg::ADDR_MASK, rv);
    chk("mask_rd", 10'h002, 10'(rv));
    bus_rd(tit_pkg::ADDR_STATUS, rv);
    chk("status_rd", 10'h003, 10'(rv));
    chk("irq_off", 10'h000, 10'(irq));
    bus_rd(tit_pkg::ADDR_STATUS, rv);
    chk("status_clr", 10'h000, 10'(rv));
    bus_rd(2'h3, rv);
    chk("unmapped_rd", 10'h000, 10'(rv));
    @(posedge mclk);
    external_interrupt_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    bus_rd(tit_pkg::ADDR_FLAGS, rv);
    chk("flags_rd", 10'h004, 10'(rv));
    exec(tit_pkg::OP_INT_ENABLE, 4'h0, 4'h0);
    @(posedge mclk);
    arst_n <= 1'b0;
    #1;
    chk("ie_rst2", 10'h000, 10'(interrupt_enable_flag));
    chk("ictl_rst2", 10'h000, 10'(int_ctrl_1));
    @(posedge mclk);
    arst_n <= 1'b1;
    exec(tit_pkg::OP_INT_ENABLE, 4'h0, 4'h0);
    chk("ie_after_rst2", 10'h001, 10'(interrupt_enable_flag));
    finish_test();
  end
endmodule
